// >>> inc/flash_pin_pkg.sv
// constants and types for the serial flash pin interface
// assumes a single 125 MHz core clock that oversamples the serial clock pin
package flash_pin_pkg;
   // transfer widths selected by the core for the data phase
   typedef enum logic [1:0] {
      width_single,
      width_dual,
      width_quad
   } line_width_e;

   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned SYNC_STAGES     = 2;
   localparam int unsigned BIT_COUNT_W     = 16;
   localparam logic [15:0] BIT_COUNT_RESET = 16'h0000;
   localparam logic [7:0]  SHIFT_RESET     = 8'h00;
   localparam logic [3:0]  OUT_RESET       = 4'h0;
   // synchroniser value after reset, {clock, select, lines 3..0}: clock low,
   // deselected, protect and hold lines at their idle high level, so that
   // no false pin edge follows reset
   localparam logic [5:0]  SYNC_RESET      = 6'h1C;
   // status protect pattern (hi, lo) under which the write protect pin guards
   localparam logic [1:0]  PROTECT_BY_PIN  = 2'h1;
   // position of the status-protect-lo bit inside that pattern
   localparam int unsigned PROTECT_LO_POS  = 0;
endpackage : flash_pin_pkg

// >>> inc/pin_sync_if.sv
// carries synchronised pin levels between the sampler and the main block
// assumes both ends share i_clk
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
   logic       sck;     // synchronised serial clock level
   logic       cs_n;    // synchronised chip select, active low
   logic [3:0] io_in;   // synchronised data lines 3..0
   modport source (output sck, cs_n, io_in);
   modport sink   (input  sck, cs_n, io_in);
endinterface : pin_sync_if
`default_nettype wire

// >>> logic/pin_sampler.sv
// two-stage synchroniser for the asynchronous serial flash pins
// assumes pins change at a rate well below i_clk
`timescale 1ns/100ps
`default_nettype none
module pin_sampler (
   // clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_resetn,
   // raw pins
   input  wire logic   i_sck,
   input  wire logic   i_cs_n,
   input  wire logic [3:0] i_io,
   // synchronised levels
   pin_sync_if.source  sync
);
   import flash_pin_pkg::*;

   typedef struct packed {
      logic [5:0] meta;
      logic [5:0] stable;
   } sampler_s;

   sampler_s state_reg;
   sampler_s state_next;

   // first stage feeds only the second stage
   always_comb begin
      state_next        = state_reg;
      state_next.meta   = {i_sck, i_cs_n, i_io};
      state_next.stable = state_reg.meta;
   end

   // chip select resets high so the device starts deselected; the protect and
   // hold lines reset high to match the edge detectors behind them
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_reg <= '{meta: SYNC_RESET, stable: SYNC_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync.sck   = state_reg.stable[5];
   assign sync.cs_n  = state_reg.stable[4];
   assign sync.io_in = state_reg.stable[3:0];
endmodule : pin_sampler
`default_nettype wire

// >>> logic/flash_pin_iface.sv
// pin-level front end of a serial flash: framing, bit capture, data launch,
// write protect and the fourth pin's hold or reset function
// assumes the core above supplies read data and the mode bits; the pin pads
// combine out/enable pairs; pull-up on write protect is emulated here
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - chip select edges frame each operation
// - deselected means standby, not deep power-down
// - input line ignored while deselected
// - output line floats while deselected
// - standby waits for self-timed cycle end
// - capture input bits on clock rise
// - launch read bits on clock fall
// - dual/quad reads drive two or four lines
// - low protect pin blocks status writes under protect pattern 01
// - quad enable turns protect pin into data
// - protect pin defaults high when floating
// - fourth pin is pause or reset
// - pause only while selected and clock low
module flash_pin_iface (
   // clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_resetn,
   // flash pins (asynchronous)
   input  wire logic                      i_sck,
   input  wire logic                      i_cs_n,
   input  wire logic [3:0]                i_io,
   output logic      [3:0]                o_io,
   output logic      [3:0]                o_io_oe,
   // write protect pad state, low when nothing drives it
   input  wire logic                      i_wp_driven,
   // mode bits from the status registers
   input  wire logic                      i_quad_enable_bit,
   input  wire logic                      i_status_protect_hi_bit,
   input  wire logic                      i_status_protect_lo_bit,
   input  wire logic                      i_hold_reset_sel,
   // core side: data phase control
   input  wire logic                      i_read_phase,
   input  wire flash_pin_pkg::line_width_e i_read_width,
   input  wire logic [3:0]                i_read_bits,
   input  wire logic                      i_busy,
   // core side: results
   output logic                           o_op_start,
   output logic                           o_op_end,
   output logic                           o_bit_valid,
   output logic                           o_bit_value,
   output logic      [15:0]               o_bit_count,
   output logic      [7:0]                o_shift,
   output logic                           o_read_advance,
   output logic                           o_selected,
   output logic                           o_standby,
   output logic                           o_status_locked,
   output logic                           o_paused,
   output logic                           o_hw_reset
);
   import flash_pin_pkg::*;

   pin_sync_if sync_bus ();

   pin_sampler u_sampler (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_sck    (i_sck),
      .i_cs_n   (i_cs_n),
      .i_io     (i_io),
      .sync     (sync_bus.source)
   );

   typedef struct packed {
      logic        sck_d;
      logic        cs_n_d;
      logic        hold_d;
      logic        wp_d;
      logic [3:0]  io;
      logic [3:0]  io_oe;
      logic        op_start;
      logic        op_end;
      logic        bit_valid;
      logic        bit_value;
      logic [15:0] bit_count;
      logic [7:0]  shift;
      logic        read_advance;
      logic        selected;
      logic        standby;
      logic        end_pending;
      logic        status_locked;
      logic        paused;
      logic        hw_reset;
   } front_s;

   front_s state_reg;
   front_s state_next;

   // mask of the lines driven in the data phase
   function automatic logic [3:0] lane_mask(input line_width_e w);
      case (w)
         width_dual: lane_mask = 4'h3;
         width_quad: lane_mask = 4'hF;
         default:    lane_mask = 4'h2;
      endcase
   endfunction : lane_mask

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic hold_pin;
   logic wp_level;
   logic hold_mode;

   // edge detection reads only the second synchroniser stage
   assign sck_rise  = sync_bus.sck & ~state_reg.sck_d;
   assign sck_fall  = ~sync_bus.sck & state_reg.sck_d;
   assign cs_fall   = ~sync_bus.cs_n & state_reg.cs_n_d;
   assign cs_rise   = sync_bus.cs_n & ~state_reg.cs_n_d;
   assign hold_pin  = sync_bus.io_in[3];
   // unused pad reads as high, like an internal pull-up
   assign wp_level  = sync_bus.io_in[2] | ~i_wp_driven;
   assign hold_mode = ~i_quad_enable_bit & ~i_hold_reset_sel;

   always_comb begin
      state_next              = state_reg;
      state_next.sck_d        = sync_bus.sck;
      state_next.cs_n_d       = sync_bus.cs_n;
      state_next.hold_d       = hold_pin;
      state_next.wp_d         = wp_level;
      state_next.op_start     = cs_fall;
      state_next.op_end       = cs_rise;
      state_next.bit_valid    = 1'b0;
      state_next.read_advance = 1'b0;

      // protect pin only guards when quad mode is off and pattern matches
      state_next.status_locked = ~i_quad_enable_bit
         & ({i_status_protect_hi_bit, i_status_protect_lo_bit} == PROTECT_BY_PIN)
         & ~state_reg.wp_d;

      // fourth pin as a level-sensitive hardware reset when selected for it
      state_next.hw_reset = ~i_quad_enable_bit & i_hold_reset_sel & ~hold_pin;

      // pause starts and ends on pin edges with the clock low, and also ends on deselect or when hold mode is off
      if (!sync_bus.cs_n && hold_mode && !sync_bus.sck) begin
         if (state_reg.hold_d && !hold_pin) begin
            state_next.paused = 1'b1;
         end else if (!state_reg.hold_d && hold_pin) begin
            state_next.paused = 1'b0;
         end
      end
      if (sync_bus.cs_n || !hold_mode) begin
         state_next.paused = 1'b0;
      end

      if (cs_fall) begin
         state_next.selected  = 1'b1;
         state_next.standby   = 1'b0;
         state_next.bit_count = BIT_COUNT_RESET;
         state_next.shift     = SHIFT_RESET;
      end

      if (sync_bus.cs_n) begin
         // deselected: lines float, clock and input ignored
         state_next.selected = 1'b0;
         state_next.io_oe    = 4'h0;
         state_next.io       = OUT_RESET;
         if (cs_rise) begin
            state_next.end_pending = 1'b1;
         end
      end else if (!state_reg.paused && !state_reg.hw_reset) begin
         if (sck_rise && !i_read_phase) begin
            state_next.bit_valid = 1'b1;
            state_next.bit_value = sync_bus.io_in[0];
            state_next.shift     = {state_reg.shift[6:0], sync_bus.io_in[0]};
            state_next.bit_count = state_reg.bit_count + 16'h0001;
         end
         if (sck_fall && i_read_phase) begin
            // single reads use line one; dual also turns line zero, quad turns all four lines
            state_next.io_oe        = lane_mask(i_read_width);
            state_next.read_advance = 1'b1;
            if (i_read_width == width_single) begin
               state_next.io = {2'b00, i_read_bits[0], 1'b0};
            end else begin
               state_next.io = i_read_bits;
            end
         end else if (!i_read_phase) begin
            state_next.io_oe = 4'h0;
         end
      end

      // standby entry deferred while a self-timed cycle runs
      if (state_reg.end_pending && sync_bus.cs_n && !i_busy) begin
         state_next.standby     = 1'b1;
         state_next.end_pending = 1'b0;
      end
      if (!sync_bus.cs_n) begin
         state_next.end_pending = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_reg <= '{sck_d: 1'b0, cs_n_d: 1'b1, hold_d: 1'b1, wp_d: 1'b1,
                        io: OUT_RESET, io_oe: 4'h0, bit_count: BIT_COUNT_RESET,
                        shift: SHIFT_RESET, standby: 1'b1, default: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_io            = state_reg.io;
   assign o_io_oe         = state_reg.io_oe;
   assign o_op_start      = state_reg.op_start;
   assign o_op_end        = state_reg.op_end;
   assign o_bit_valid     = state_reg.bit_valid;
   assign o_bit_value     = state_reg.bit_value;
   assign o_bit_count     = state_reg.bit_count;
   assign o_shift         = state_reg.shift;
   assign o_read_advance  = state_reg.read_advance;
   assign o_selected      = state_reg.selected;
   assign o_standby       = state_reg.standby;
   assign o_status_locked = state_reg.status_locked;
   assign o_paused        = state_reg.paused;
   assign o_hw_reset      = state_reg.hw_reset;
endmodule : flash_pin_iface
`default_nettype wire

// >>> test/flash_host_model.sv
// host side model: drives chip select, serial clock and data lines
// assumes i_clk is the core clock; 10 of its periods make half a link clock
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
   // time base
   input  wire logic      i_clk,
   // host pins
   output var  logic      o_sck,
   output var  logic [3:0] o_io,
   output var  logic      o_cs_n
);
   // link clock parks low, lines 3 and 2 idle high
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'hC;
   end
   // half a link period, 80 ns
   task automatic half();
      repeat (10) @(negedge i_clk);
   endtask : half
   // frame edge; released lines flip so a stale bit never passes for data
   task automatic frame(input logic open);
      o_cs_n = !open;
      if (!open) begin
         o_io[1:0] = ~o_io[1:0];
      end
      half();
   endtask : frame
   // one bit on line 0, set while the clock is low
   task automatic send(input logic b);
      o_io[0] = b;
      half();
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
   endtask : send
   // one clock for read data, launched by the device at the fall
   task automatic rdclk();
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
      half();
   endtask : rdclk
   // pin level change, only called with the link clock low
   task automatic pin(input int n, input logic v);
      o_io[n] = v;
      half();
   endtask : pin
endmodule : flash_host_model
`default_nettype wire

// >>> test/flash_pin_iface_checker.sv
// concurrent checks on the pin front end, top ports only
// assumes pins move off the sampling edge of i_clk
`timescale 1ns/100ps
`default_nettype none
module flash_pin_iface_checker (
   // clock and reset
   input wire logic                       i_clk,
   input wire logic                       i_resetn,
   // pins and modes
   input wire logic                       i_cs_n,
   input wire logic [3:0]                 i_io,
   input wire logic [3:0]                 o_io_oe,
   input wire logic                       i_wp_driven,
   input wire logic                       i_quad_enable_bit,
   input wire logic                       i_hold_reset_sel,
   input wire flash_pin_pkg::line_width_e i_read_width,
   input wire logic                       i_busy,
   // results
   input wire logic                       o_op_start,
   input wire logic                       o_op_end,
   input wire logic                       o_bit_valid,
   input wire logic                       o_read_advance,
   input wire logic                       o_selected,
   input wire logic                       o_standby,
   input wire logic                       o_status_locked,
   input wire logic                       o_hw_reset
);
   import flash_pin_pkg::*;
   // four cycles cover the two sync stages plus the output register
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   a_oe_idle: assert property (i_cs_n [*4] |-> o_io_oe == 4'h0)
      else $error("output enabled while deselected");
   a_op_start: assert property ($fell(i_cs_n) |-> ##[2:4] o_op_start)
      else $error("no start after select");
   a_op_end: assert property ($rose(i_cs_n) |-> ##[2:4] o_op_end)
      else $error("no end after deselect");
   a_no_capture: assert property (i_cs_n [*4] |-> !o_bit_valid)
      else $error("bit captured while deselected");
   a_standby_hold: assert property (i_busy && !o_standby |=> !o_standby)
      else $error("standby entered while busy");
   a_select_wake: assert property (o_selected |-> !o_standby)
      else $error("standby while selected");
   a_pull_up: assert property (!i_wp_driven [*4] |-> !o_status_locked)
      else $error("floating protect pin locks");
   a_quad_free: assert property (i_quad_enable_bit [*4] |-> !o_status_locked)
      else $error("protect pin locks in quad mode");
   a_quad_drive: assert property (o_read_advance && i_read_width == width_quad
      |-> o_io_oe == 4'hF)
      else $error("quad read not on four lines");
   a_reset_pin: assert property ((!i_quad_enable_bit && i_hold_reset_sel && !i_io[3]) [*4]
      |-> o_hw_reset)
      else $error("reset pin ignored");
endmodule : flash_pin_iface_checker
bind flash_pin_iface flash_pin_iface_checker flash_pin_iface_checker_inst (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_io(i_io),
   .o_io_oe(o_io_oe), .i_wp_driven(i_wp_driven), .i_quad_enable_bit(i_quad_enable_bit),
   .i_hold_reset_sel(i_hold_reset_sel), .i_read_width(i_read_width), .i_busy(i_busy),
   .o_op_start(o_op_start), .o_op_end(o_op_end), .o_bit_valid(o_bit_valid),
   .o_read_advance(o_read_advance), .o_selected(o_selected), .o_standby(o_standby),
   .o_status_locked(o_status_locked), .o_hw_reset(o_hw_reset));
`default_nettype wire

// >>> test/flash_pin_iface_tb.sv
// self-checking bench for the pin front end with a host model
// assumes the checker is bound in; waits are fixed counts from the latency
`timescale 1ns/100ps
`default_nettype none
module flash_pin_iface_tb;
   import flash_pin_pkg::*;
   // clock, reset, pins
   logic i_clk;
   logic i_resetn;
   logic sck, cs_n;
   logic [3:0] host_io, wire_io, o_io, o_io_oe;
   // modes and core side, all set by the main sequence
   logic wp_drv, qe, hold_sel, rd_phase, busy, prot_hi, prot_lo;
   line_width_e rd_width;
   logic [3:0] rd_bits;
   logic [7:0] wbyte = 8'hA5;
   logic [3:0] oe_tab [3] = '{4'h2, 4'h3, 4'hF};
   // launch values per width and what the enabled lines must then show
   logic [3:0] bit_tab [3] = '{4'h1, 4'h2, 4'hD};
   logic [3:0] io_tab [3] = '{4'h2, 4'h2, 4'hD};
   logic op_start, op_end, bit_valid, bit_value, rd_adv, sel, stby, locked, paused, hw_rst;
   logic [15:0] count;
   logic [7:0] shift;
   int bad_count = 0;
   int check_count = 0;
   int adv_seen = 0;
   int start_seen = 0;
   always #4 i_clk = ~i_clk;
   // pulse counters, sampled mid-cycle where registered outputs are settled
   always @(negedge i_clk) begin
      if (rd_adv === 1'b1) begin
         adv_seen++;
      end
      if (op_start === 1'b1) begin
         start_seen++;
      end
   end
   // a driving device wins the line over the host
   assign wire_io = (o_io & o_io_oe) | (host_io & ~o_io_oe);
   flash_host_model host_inst (.i_clk(i_clk), .o_sck(sck), .o_io(host_io), .o_cs_n(cs_n));
   flash_pin_iface flash_pin_iface_inst (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_sck(sck), .i_cs_n(cs_n), .i_io(wire_io),
      .o_io(o_io), .o_io_oe(o_io_oe), .i_wp_driven(wp_drv), .i_quad_enable_bit(qe),
      .i_status_protect_hi_bit(prot_hi), .i_status_protect_lo_bit(prot_lo),
      .i_hold_reset_sel(hold_sel), .i_read_phase(rd_phase), .i_read_width(rd_width),
      .i_read_bits(rd_bits), .i_busy(busy), .o_op_start(op_start), .o_op_end(op_end),
      .o_bit_valid(bit_valid), .o_bit_value(bit_value), .o_bit_count(count),
      .o_shift(shift), .o_read_advance(rd_adv), .o_selected(sel), .o_standby(stby),
      .o_status_locked(locked), .o_paused(paused), .o_hw_reset(hw_rst));
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask : chk
   task automatic end_of_test();
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   // main sequence, inputs move on the falling edge only
   initial begin
      i_clk = 1'b0;
      i_resetn = 1'b0;
      wp_drv = 1'b1;
      qe = 1'b0;
      hold_sel = 1'b0;
      rd_phase = 1'b0;
      busy = 1'b0;
      prot_hi = 1'b0;
      prot_lo = 1'b1;
      rd_width = width_single;
      rd_bits = 4'h0;
      tick(20);
      i_resetn = 1'b1;
      tick(3);
      chk("standby", 16'h1, stby);
      host_inst.frame(1'b1);
      for (int i = 7; i >= 0; i--) begin
         host_inst.send(wbyte[i]);
      end
      tick(5);
      chk("shift", 16'hA5, shift);
      chk("count", 16'h8, count);
      chk("bit_value", 16'h1, bit_value);
      chk("selected", 16'h1, sel);
      chk("standby", 16'h0, stby);
      host_inst.frame(1'b0);
      chk("selected", 16'h0, sel);
      host_inst.send(1'b0);
      tick(5);
      chk("shift", 16'hA5, shift);
      busy = 1'b1;
      host_inst.frame(1'b1);
      chk("count", 16'h0, count);
      host_inst.frame(1'b0);
      chk("standby", 16'h0, stby);
      busy = 1'b0;
      tick(3);
      chk("standby", 16'h1, stby);
      // reads on one, two and four lines
      qe = 1'b1;
      rd_phase = 1'b1;
      host_inst.frame(1'b1);
      for (int w = 0; w < 3; w++) begin
         rd_width = line_width_e'(w);
         rd_bits = bit_tab[w];
         host_inst.rdclk();
         chk("oe", {12'h0, oe_tab[w]}, o_io_oe);
         chk("io", {12'h0, io_tab[w]}, o_io & o_io_oe);
      end
      chk("count", 16'h0, count);
      chk("advance", 16'h3, 16'(adv_seen));
      host_inst.frame(1'b0);
      chk("oe", 16'h0, o_io_oe);
      // protect pin low is only data while quad mode is on
      host_inst.pin(2, 1'b0);
      chk("locked", 16'h0, locked);
      rd_phase = 1'b0;
      qe = 1'b0;
      tick(5);
      chk("locked", 16'h1, locked);
      // protect pattern 00 leaves the pin without effect
      prot_lo = 1'b0;
      tick(5);
      chk("locked", 16'h0, locked);
      prot_lo = 1'b1;
      tick(5);
      chk("locked", 16'h1, locked);
      // pull-up on a floating protect pad
      wp_drv = 1'b0;
      tick(5);
      chk("locked", 16'h0, locked);
      wp_drv = 1'b1;
      host_inst.pin(2, 1'b1);
      // pause ignores clocks until released
      host_inst.frame(1'b1);
      host_inst.pin(3, 1'b0);
      chk("paused", 16'h1, paused);
      host_inst.send(1'b1);
      tick(5);
      chk("count", 16'h0, count);
      host_inst.pin(3, 1'b1);
      chk("paused", 16'h0, paused);
      host_inst.send(1'b1);
      tick(5);
      chk("count", 16'h1, count);
      host_inst.frame(1'b0);
      hold_sel = 1'b1;
      host_inst.pin(3, 1'b0);
      chk("hw_reset", 16'h1, hw_rst);
      host_inst.pin(3, 1'b1);
      chk("hw_reset", 16'h0, hw_rst);
      chk("starts", 16'h4, 16'(start_seen));
      end_of_test();
   end
endmodule : flash_pin_iface_tb
`default_nettype wire
